// >>> shared/dtc_pkg.sv
// Constants, register map and mode encodings of the dual timer/counter.
// Assumes an 8-bit register port and a single 10 MHz core clock.
package dtc_pkg;
	// ==========================================================
	// Register port geometry
	localparam int AW = 4;
	localparam int DW = 8;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] DTC_OFF_CTL1  = 4'h0;
	localparam logic [3:0] DTC_OFF_CMP1H = 4'h1;
	localparam logic [3:0] DTC_OFF_CMP1L = 4'h2;
	localparam logic [3:0] DTC_OFF_CNT1H = 4'h3;
	localparam logic [3:0] DTC_OFF_CNT1L = 4'h4;
	localparam logic [3:0] DTC_OFF_CTL2  = 4'h5;
	localparam logic [3:0] DTC_OFF_CMP2  = 4'h6;
	localparam logic [3:0] DTC_OFF_CNT2  = 4'h7;
	localparam logic [3:0] DTC_OFF_FF    = 4'h8;
	localparam logic [3:0] DTC_OFF_STAT  = 4'h9;

	// ==========================================================
	// Field positions
	localparam int DTC_MODE_LSB = 0;
	localparam int DTC_ES1_BIT  = 2;
	localparam int DTC_SEL1_LSB = 3;
	localparam int DTC_SEL2_LSB = 2;
	localparam int DTC_RUN_BIT  = 7;
	localparam int DTC_ST1_BIT  = 0;
	localparam int DTC_ST2_BIT  = 1;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0]  DTC_CTL_RST  = 8'h00;
	localparam logic [7:0]  DTC_BYTE_RST = 8'h00;
	localparam logic [15:0] DTC_CNT1_RST = 16'h0000;
	localparam logic [7:0]  DTC_CNT2_MAX = 8'hFF;
	localparam logic [7:0]  DTC_PRE_RST  = 8'h00;

	// ==========================================================
	// Mode encodings
	typedef enum logic [1:0] {
		DTC_M1_TIMER   = 2'b00,
		DTC_M1_COUNTER = 2'b01,
		DTC_M1_WINDOW  = 2'b10
	} dtc_mode1_t;

	typedef enum logic [1:0] {
		DTC_M2_TIMER   = 2'b00,
		DTC_M2_COUNTER = 2'b01,
		DTC_M2_PDO     = 2'b10,
		DTC_M2_PWM     = 2'b11
	} dtc_mode2_t;
endpackage : dtc_pkg

// >>> shared/dtc_pin_if.sv
// Synchronised pin level with its edge pulses.
// Assumes producer and consumer share sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface dtc_pin_if;
	logic lvl;
	logic rise;
	logic fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface : dtc_pin_if
`default_nettype wire

// >>> verilog/dtc_pin_sync.sv
// Two-flop synchroniser and edge detector for one input pin.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic pin_i,
	dtc_pin_if.src    sig
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// ==========================================================
	// Synchroniser chain plus one history stage
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Edges seen only past the second stage
	assign sig.lvl  = s2_reg;
	assign sig.rise = s2_reg & ~s3_reg;
	assign sig.fall = ~s2_reg & s3_reg;
endmodule : dtc_pin_sync
`default_nettype wire

// >>> verilog/dtc_timer.sv
// Two up-counters: 16-bit timer/counter/window, 8-bit timer/counter/divider/PWM.
// Assumes an 8-bit register port on the core clock and async count pins.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - Counters and prescaler keep running while the core sleeps.
// R02 - First counter, timer mode: counts selected internal clock.
// R03 - First counter match: interrupt, clear, resume from zero, every mode.
// R04 - First counter, counter mode: counts its external pin.
// R05 - Edge-select bit picks rising or falling pin edges.
// R06 - Window mode counts rising edges of internal clock AND pin.
// R07 - Outside party keeps the window slower than the internal clock.
// R08 - Second counter, timer mode: counts internal clock rising edges.
// R09 - Second counter, counter mode: counts its own external pin.
// R10 - Second counter timer/counter match: interrupt, clear, resume.
// R11 - Divider mode: match toggles flip-flop and clears, square wave.
// R12 - Divider mode: inverted flip-flop drives the active-low divider pin.
// R13 - Flip-flop resets to zero and software can write it.
// R14 - Divider mode: interrupt at every output toggle.
// R15 - PWM mode: match toggles flip-flop, counter keeps running.
// R16 - PWM mode: overflow toggles again and clears the counter.
// R17 - PWM mode: inverted flip-flop on PWM pin, interrupt per overflow.
// R18 - PWM compare is double buffered, new value at period end.
// R19 - Setting start bit loads the compare into the active stage.
// R20 - Each counter has writable mode and clock-select fields.
// R21 - First compare is high byte above low byte, sixteen bits.
module dtc_timer (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rstn_i,
	input  wire logic [dtc_pkg::AW-1:0] addr_i,
	input  wire logic [dtc_pkg::DW-1:0] wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output var  logic [dtc_pkg::DW-1:0] rdata_o,
	input  wire logic                   sleep_instruction_i,
	input  wire logic                   first_counter_input_pin_i,
	input  wire logic                   second_counter_input_pin_i,
	output var  logic                   tc1_irq_o,
	output var  logic                   tc2_irq_o,
	output var  logic                   divider_output_n_o,
	output var  logic                   pwm_output_n_o
);
	import dtc_pkg::*;

	logic [7:0]  ctl1_reg;
	logic [7:0]  cmp1h_reg;
	logic [7:0]  cmp1l_reg;
	logic [7:0]  ctl2_reg;
	logic [7:0]  cmp2_buf_reg;
	logic [7:0]  cmp2_act_reg;
	logic [15:0] cnt1_reg;
	logic [7:0]  cnt2_reg;
	logic [7:0]  pre_reg;
	logic        clk1_d_reg;
	logic        clk2_d_reg;
	logic        win_d_reg;
	logic        ff_reg;
	logic [1:0]  stat_reg;
	logic [7:0]  rdata_reg;
	logic        irq1_reg;
	logic        irq2_reg;
	logic        pdo_n_reg;
	logic        pwm_n_reg;
	dtc_mode1_t  mode1;
	dtc_mode2_t  mode2;
	logic [2:0]  sel1;
	logic [2:0]  sel2;
	logic [15:0] first_compare_value;
	logic [15:0] cnt1_next;
	logic [7:0]  cnt2_next;
	logic        clk1_lvl;
	logic        clk2_lvl;
	logic        clk1_rise;
	logic        clk2_rise;
	logic        win_lvl;
	logic        win_rise;
	logic        ev1;
	logic        ev2;
	logic        match1;
	logic        match2;
	logic        pwm_hit;
	logic        pwm_ovf;
	logic        toggle;
	logic        start_rise;
	logic        wr_ctl2;
	logic        wr_ff;

	dtc_pin_if pin1 ();
	dtc_pin_if pin2 ();

	// ==========================================================
	// Pin synchronisers
	dtc_pin_sync u_sync1 (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.pin_i     (first_counter_input_pin_i),
		.sig       (pin1)
	);
	dtc_pin_sync u_sync2 (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.pin_i     (second_counter_input_pin_i),
		.sig       (pin2)
	);

	// ==========================================================
	// Register writes
	assign wr_ctl2    = wr_i && (addr_i == DTC_OFF_CTL2);
	assign wr_ff      = wr_i && (addr_i == DTC_OFF_FF);
	assign start_rise = wr_ctl2 && wdata_i[DTC_RUN_BIT] && !ctl2_reg[DTC_RUN_BIT];

	// Control and compare storage
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl1_reg     <= DTC_CTL_RST;
			cmp1h_reg    <= DTC_BYTE_RST;
			cmp1l_reg    <= DTC_BYTE_RST;
			ctl2_reg     <= DTC_CTL_RST;
			cmp2_buf_reg <= DTC_BYTE_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				DTC_OFF_CTL1:  ctl1_reg     <= wdata_i; // R20
				DTC_OFF_CMP1H: cmp1h_reg    <= wdata_i;
				DTC_OFF_CMP1L: cmp1l_reg    <= wdata_i;
				DTC_OFF_CTL2:  ctl2_reg     <= wdata_i; // R20
				DTC_OFF_CMP2:  cmp2_buf_reg <= wdata_i; // R18
				default: ;
			endcase
		end
	end

	// Field decode
	assign mode1 = dtc_mode1_t'(ctl1_reg[DTC_MODE_LSB +: 2]);
	assign mode2 = dtc_mode2_t'(ctl2_reg[DTC_MODE_LSB +: 2]);
	assign sel1  = ctl1_reg[DTC_SEL1_LSB +: 3];
	assign sel2  = ctl2_reg[DTC_SEL2_LSB +: 3];
	assign first_compare_value = {cmp1h_reg, cmp1l_reg}; // R21

	// ==========================================================
	// Prescaler; sleep does not gate it
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_reg <= DTC_PRE_RST;
		end else begin
			pre_reg <= pre_reg + 8'h01; // R01
		end
	end

	// Internal clock levels, divide by 2 to 256
	assign clk1_lvl = pre_reg[sel1];
	assign clk2_lvl = pre_reg[sel2];
	assign win_lvl  = clk1_lvl & pin1.lvl; // R06

	// Edge history of internal clocks and window
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk1_d_reg <= 1'b0;
			clk2_d_reg <= 1'b0;
			win_d_reg  <= 1'b0;
		end else begin
			clk1_d_reg <= clk1_lvl;
			clk2_d_reg <= clk2_lvl;
			win_d_reg  <= win_lvl;
		end
	end

	assign clk1_rise = clk1_lvl & ~clk1_d_reg;
	assign clk2_rise = clk2_lvl & ~clk2_d_reg;
	assign win_rise  = win_lvl & ~win_d_reg;

	// ==========================================================
	// First counter: count event per mode
	always_comb begin
		ev1 = 1'b0;
		unique case (mode1)
			DTC_M1_TIMER:   ev1 = clk1_rise; // R02
			DTC_M1_COUNTER: ev1 = ctl1_reg[DTC_ES1_BIT] ? pin1.rise : pin1.fall; // R04 R05
			DTC_M1_WINDOW:  ev1 = win_rise; // R06 R07
			default:        ev1 = 1'b0;
		endcase
		ev1 = ev1 & ctl1_reg[DTC_RUN_BIT];
	end

	assign cnt1_next = cnt1_reg + 16'h0001;
	assign match1    = ev1 && (cnt1_next == first_compare_value);

	// Count up, clear on match
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt1_reg <= DTC_CNT1_RST;
		end else if (ev1) begin
			cnt1_reg <= match1 ? DTC_CNT1_RST : cnt1_next; // R03
		end
	end

	// ==========================================================
	// Second counter: count event per mode
	always_comb begin
		ev2 = 1'b0;
		unique case (mode2)
			DTC_M2_TIMER:   ev2 = clk2_rise; // R08
			DTC_M2_COUNTER: ev2 = pin2.rise; // R09
			DTC_M2_PDO:     ev2 = clk2_rise; // R11
			DTC_M2_PWM:     ev2 = clk2_rise; // R15
		endcase
		ev2 = ev2 & ctl2_reg[DTC_RUN_BIT];
	end

	assign cnt2_next = cnt2_reg + 8'h01;
	assign match2  = ev2 && (mode2 != DTC_M2_PWM) && (cnt2_next == cmp2_buf_reg);
	assign pwm_ovf = ev2 && (mode2 == DTC_M2_PWM) && (cnt2_reg == DTC_CNT2_MAX);
	assign pwm_hit = ev2 && (mode2 == DTC_M2_PWM) && !pwm_ovf
		&& (cnt2_next == cmp2_act_reg);
	assign toggle  = (match2 && (mode2 == DTC_M2_PDO)) || pwm_hit || pwm_ovf;

	// Count up, clear on match or PWM overflow
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt2_reg <= DTC_BYTE_RST;
		end else if (ev2) begin
			cnt2_reg <= (match2 || pwm_ovf) ? DTC_BYTE_RST : cnt2_next; // R10 R11 R16
		end
	end

	// Active PWM compare stage
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmp2_act_reg <= DTC_BYTE_RST;
		end else if (start_rise || pwm_ovf) begin
			cmp2_act_reg <= cmp2_buf_reg; // R18 R19
		end
	end

	// Output flip-flop, software write has priority
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ff_reg <= 1'b0; // R13
		end else if (wr_ff) begin
			ff_reg <= wdata_i[0]; // R13
		end else if (toggle) begin
			ff_reg <= ~ff_reg; // R11 R15 R16
		end
	end

	// Pin drivers, idle high when mode is off
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pdo_n_reg <= 1'b1;
			pwm_n_reg <= 1'b1;
		end else begin
			pdo_n_reg <= (mode2 == DTC_M2_PDO) ? ~ff_reg : 1'b1; // R12
			pwm_n_reg <= (mode2 == DTC_M2_PWM) ? ~ff_reg : 1'b1; // R17
		end
	end

	// ==========================================================
	// Interrupt pulses and sticky status, set wins over clear
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq1_reg <= 1'b0;
			irq2_reg <= 1'b0;
			stat_reg <= 2'h0;
		end else begin
			irq1_reg <= match1; // R03
			irq2_reg <= match2 || pwm_ovf; // R10 R14 R17
			stat_reg <= (stat_reg & ~((wr_i && addr_i == DTC_OFF_STAT) ? wdata_i[1:0] : 2'h0))
				| {match2 || pwm_ovf, match1};
		end
	end

	// ==========================================================
	// Read port, data one cycle after strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_reg <= DTC_BYTE_RST;
		end else if (rd_i) begin
			unique case (addr_i)
				DTC_OFF_CTL1:  rdata_reg <= ctl1_reg;
				DTC_OFF_CMP1H: rdata_reg <= cmp1h_reg;
				DTC_OFF_CMP1L: rdata_reg <= cmp1l_reg;
				DTC_OFF_CNT1H: rdata_reg <= cnt1_reg[15:8];
				DTC_OFF_CNT1L: rdata_reg <= cnt1_reg[7:0];
				DTC_OFF_CTL2:  rdata_reg <= ctl2_reg;
				DTC_OFF_CMP2:  rdata_reg <= cmp2_buf_reg;
				DTC_OFF_CNT2:  rdata_reg <= cnt2_reg;
				DTC_OFF_FF:    rdata_reg <= {7'h00, ff_reg};
				DTC_OFF_STAT:  rdata_reg <= {6'h00, stat_reg};
				default:       rdata_reg <= DTC_BYTE_RST;
			endcase
		end else begin
			rdata_reg <= DTC_BYTE_RST;
		end
	end

	assign rdata_o            = rdata_reg;
	assign tc1_irq_o          = irq1_reg;
	assign tc2_irq_o          = irq2_reg;
	assign divider_output_n_o = pdo_n_reg;
	assign pwm_output_n_o     = pwm_n_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_match1_clear: assert property (match1 |=> cnt1_reg == 16'h0000 && tc1_irq_o) // R03
		else $error("first counter not cleared on match");
	a_cnt1_timer: assert property (mode1 == DTC_M1_TIMER && ctl1_reg[DTC_RUN_BIT]
		&& clk1_rise && !match1 && !wr_i |=> cnt1_reg == $past(cnt1_reg) + 16'h0001) // R02
		else $error("first counter missed an internal clock");
	a_edge_select: assert property (mode1 == DTC_M1_COUNTER && ctl1_reg[DTC_RUN_BIT]
		&& !ctl1_reg[DTC_ES1_BIT] && pin1.rise |-> !ev1) // R05
		else $error("rising edge counted in falling-edge mode");
	a_sleep_runs: assert property (sleep_instruction_i && ev2 && !match2 && !pwm_ovf
		|=> cnt2_reg != $past(cnt2_reg)) // R01
		else $error("second counter stalled during sleep");
	a_pdo_toggle: assert property (mode2 == DTC_M2_PDO && match2 && !wr_ff
		|=> ff_reg != $past(ff_reg) && tc2_irq_o && cnt2_reg == 8'h00) // R11
		else $error("divider match did not toggle and clear");
	a_pdo_pin: assert property (mode2 == DTC_M2_PDO && $past(mode2) == DTC_M2_PDO
		|-> divider_output_n_o == !$past(ff_reg)) // R12
		else $error("divider pin not inverted flip-flop");
	a_pwm_irq: assert property (mode2 == DTC_M2_PWM && $rose(tc2_irq_o)
		|-> $past(cnt2_reg) == 8'hFF && cnt2_reg == 8'h00) // R17
		else $error("pwm interrupt without overflow");
	a_pwm_hold: assert property ($changed(cmp2_act_reg) |-> $past(start_rise || pwm_ovf)) // R18
		else $error("active compare changed mid period");
	a_ff_write: assert property (wr_ff |=> ff_reg == $past(wdata_i[0])) // R13
		else $error("flip-flop write lost");
	a_pwm_mid: assert property (pwm_hit && !wr_ff |=> ff_reg != $past(ff_reg)
		&& cnt2_reg == $past(cnt2_reg) + 8'h01) // R15
		else $error("pwm match mishandled");
	// Overflow and start bit both refresh the active compare
	a_pwm_wrap: assert property (pwm_ovf && !wr_ff |=> ff_reg != $past(ff_reg)
		&& cnt2_reg == 8'h00 && cmp2_act_reg == $past(cmp2_buf_reg)) // R16
		else $error("pwm overflow mishandled");
	a_start_load: assert property (start_rise |=> cmp2_act_reg == $past(cmp2_buf_reg)) // R19
		else $error("start bit did not load compare");

	c_first_match: cover property (match1 && mode1 == DTC_M1_WINDOW);
	c_pdo_toggle:  cover property (match2 && mode2 == DTC_M2_PDO);
	c_pwm_period:  cover property (pwm_hit ##[1:600] pwm_ovf);
	c_sleep_count: cover property (sleep_instruction_i && ev1);
endmodule : dtc_timer
`default_nettype wire

// >>> verif/dtc_pin_model.sv
// Far-side model: square waves on the two count input pins.
// Assumes half periods in core clocks from the bench; zero holds a pin low.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] half1_i,
	input  wire logic [7:0] half2_i,
	output var  logic       pin1_o,
	output var  logic       pin2_o
);
	int c1 = 0;
	int c2 = 0;
	initial pin1_o = 1'b0;
	initial pin2_o = 1'b0;
	// ==========================================================
	// Pin 1, also the gating window, kept slower than the internal clock
	always @(posedge sys_clk_i) begin
		if (half1_i == 8'h00) begin
			pin1_o <= 1'b0;
			c1 = 0;
		end else if (++c1 >= half1_i) begin
			pin1_o <= ~pin1_o;
			c1 = 0;
		end
	end
	// Pin 2, count input of the second counter
	always @(posedge sys_clk_i) begin
		if (half2_i == 8'h00) begin
			pin2_o <= 1'b0;
			c2 = 0;
		end else if (++c2 >= half2_i) begin
			pin2_o <= ~pin2_o;
			c2 = 0;
		end
	end
endmodule : dtc_pin_model
`default_nettype wire

// >>> verif/dual_timer_counter_pdo_pwm_bench.sv
// Self-checking bench: register port, counter periods, divider and PWM pins.
// Assumes the pin model on the count inputs and a 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
	$display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module dual_timer_counter_pdo_pwm_bench;
	import dtc_pkg::*;
	logic          sys_clk_i   = 1'b0;
	logic          rstn_i      = 1'b0;
	logic [AW-1:0] addr_i      = '0;
	logic [DW-1:0] wdata_i     = '0;
	logic          wr_i        = 1'b0;
	logic          rd_i        = 1'b0;
	logic          sleep_i     = 1'b0;
	logic [7:0]    half1       = 8'h00;
	logic [7:0]    half2       = 8'h00;
	logic          pin1, pin2, irq1, irq2, div_n, pwm_n;
	logic [DW-1:0] rdata;
	logic [DW-1:0] d;
	logic [11:0]   tv [4]      = '{12'h51C, 12'h038, 12'h801, 12'h800};
	int            err_total   = 0;
	int            check_count = 0;
	int            seed        = 84;
	int            n, lowc, lo;
	// ==========================================================
	// Clock, device and far side
	always #50 sys_clk_i = ~sys_clk_i;
	dtc_timer u_dut (
		.sys_clk_i                  (sys_clk_i),
		.rstn_i                     (rstn_i),
		.addr_i                     (addr_i),
		.wdata_i                    (wdata_i),
		.wr_i                       (wr_i),
		.rd_i                       (rd_i),
		.rdata_o                    (rdata),
		.sleep_instruction_i        (sleep_i),
		.first_counter_input_pin_i  (pin1),
		.second_counter_input_pin_i (pin2),
		.tc1_irq_o                  (irq1),
		.tc2_irq_o                  (irq2),
		.divider_output_n_o         (div_n),
		.pwm_output_n_o             (pwm_n)
	);
	dtc_pin_model u_pins (
		.sys_clk_i (sys_clk_i),
		.half1_i   (half1),
		.half2_i   (half2),
		.pin1_o    (pin1),
		.pin2_o    (pin2)
	);
	// ==========================================================
	// Register port tasks
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge sys_clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i   <= 1'b0;
		#1;
		v = rdata;
	endtask : rd
	// Cycles between two interrupt pulses, PWM pin low time counted alongside
	task automatic gap(input int sel, input bit skip, output int cyc, output int low);
		int k;
		logic dv;
		cyc = 0;
		low = 0;
		for (k = 0; k < 3000 && !skip; k++) begin
			@(posedge sys_clk_i);
			#1;
			if ((sel == 1 ? irq1 : irq2) === 1'b1) break;
		end
		dv = div_n;
		for (k = 0; k < 3000; k++) begin
			@(posedge sys_clk_i);
			#1;
			cyc++;
			if (pwm_n === 1'b0) low++;
			if ((sel == 1 ? irq1 : irq2) === 1'b1) break;
		end
		if (sel == 3) `CHK("divider toggle", ~dv, div_n)
	endtask : gap
	// Model of PWM low time: match at event c, overflow at event 256
	function automatic int pwm_low(input int c, input int per);
		return (256 - c) * per;
	endfunction : pwm_low
	// Verdict and end of run
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	// ==========================================================
	// Watchdog
	initial begin
		#(20000 * 100);
		err_total++;
		complete_run();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rstn_i  <= 1'b1;
		sleep_i <= 1'b1;
		#1;
		`CHK("divider pin", 1'b1, div_n)
		`CHK("pwm pin", 1'b1, pwm_n)
		// Reset values, unmapped write ignored
		wr(4'hF, 8'hA5);
		for (int a = 0; a < 11; a++) begin
			rd((a == 10) ? 4'hF : a[3:0], d);
			`CHK("reset read", 8'h00, d)
		end
		// Control fields and flip-flop write readback
		foreach (tv[i]) begin
			wr(tv[i][11:8], tv[i][7:0]);
			rd(tv[i][11:8], d);
			`CHK("readback", tv[i][7:0], d)
		end
		// PWM: first load by start bit, then buffered update
		wr(DTC_OFF_CMP2, 8'h40);
		wr(DTC_OFF_CTL2, 8'h83);
		gap(2, 1'b0, n, lowc);
		`CHK("pwm period", 512, n)
		`CHK("pwm low", pwm_low(64, 2), lowc)
		wr(DTC_OFF_CMP2, 8'hC0);
		gap(2, 1'b1, n, lowc);
		`CHK("pwm low old", pwm_low(64, 2), lowc)
		gap(2, 1'b1, n, lowc);
		`CHK("pwm low new", pwm_low(192, 2), lowc)
		// Divider output mode
		wr(DTC_OFF_CMP2, 8'h03);
		wr(DTC_OFF_CTL2, 8'h82);
		gap(3, 1'b0, n, lowc);
		`CHK("divider half period", 6, n)
		gap(3, 1'b1, n, lowc);
		`CHK("divider irq", 6, n)
		// Second counter on its pin, rising edges every 8 clocks
		half2 <= 8'd4;
		wr(DTC_OFF_CTL2, 8'h81);
		gap(2, 1'b0, n, lowc);
		`CHK("counter2 period", 24, n)
		wr(DTC_OFF_CTL2, 8'h80);
		gap(2, 1'b0, n, lowc);
		`CHK("timer2 period", 6, n)
		wr(DTC_OFF_CTL2, 8'h00);
		// First counter timer mode, 16-bit compare, internal period 4
		lo = 2 + {$random(seed)} % 8;
		wr(DTC_OFF_CMP1H, 8'h01);
		wr(DTC_OFF_CMP1L, lo[7:0]);
		wr(DTC_OFF_CTL1, 8'h88);
		gap(1, 1'b0, n, lowc);
		`CHK("timer1 period", (256 + lo) * 4, n)
		gap(1, 1'b1, n, lowc);
		`CHK("timer1 resume", (256 + lo) * 4, n)
		// First counter on its pin, one edge kind only
		wr(DTC_OFF_CMP1H, 8'h00);
		wr(DTC_OFF_CMP1L, 8'h04);
		half1 <= 8'd4;
		for (int es = 0; es < 2; es++) begin
			wr(DTC_OFF_CTL1, 8'h81 | (es[7:0] << 2));
			gap(1, 1'b0, n, lowc);
			`CHK("counter1 period", 32, n)
			`CHK("counter1 edge", es[0], pin1)
		end
		// Window mode: ten events per 40-clock window period, twenty matches in 400
		half1 <= 8'd20;
		wr(DTC_OFF_CMP1L, 8'h05);
		wr(DTC_OFF_CTL1, 8'h82);
		n = 0;
		repeat (400) begin
			@(posedge sys_clk_i);
			#1;
			if (irq1 === 1'b1) n++;
		end
		`CHK("window irqs", 1'b1, (n >= 19 && n <= 21))
		complete_run();
	end
endmodule : dual_timer_counter_pdo_pwm_bench
`default_nettype wire
